// ---- design/therm_core.sv ----
// Thermometer register set behind a two-wire serial bus
`timescale 1ns/1ps
module therm_core #(
  parameter int conv_cyc_12 = therm_pkg::CONV_CYC_12,
  parameter int nv_write_cyc = therm_pkg::NV_WRITE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Two-wire bus, data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps
  input wire logic [2:0] addr_pins,
  // Sensor front end
  input wire logic [15:0] temp_sample,
  // Thermostat
  output logic tout
);
  typedef struct packed {
    logic scl_s1, scl_s2, scl_f, scl_fd;
    logic [3:0] scl_cnt;
    logic sda_s1, sda_s2, sda_f, sda_fd;
    logic [3:0] sda_cnt;
    logic [2:0] adr_s1, adr_s2;
    therm_pkg::link_t lst;
    logic [7:0] sh;
    logic [3:0] bitcnt;
    logic [2:0] byte_idx;
    logic rd, rd_lo;
    logic [7:0] cmd;
    logic [7:0] wbuf;
    logic sda_oe;
    logic nv_wr;
    logic [1:0] nv_sel;
    logic [15:0] nv_dat;
    therm_pkg::conv_t cst;
    logic [therm_pkg::CONV_CNT_W-1:0] conv_cnt;
    logic [15:0] temp;
    logic converted, done, thf, tlf, act, tout;
    logic [1:0] res;
  } core_t;

  core_t s_r;
  core_t s_nxt;
  logic [15:0] th_q, tl_q, thm, tlm, tm, rword;
  logic [1:0] nv_cfg;
  logic nv_busy;
  logic [7:0] cfg_byte, rbyte;
  logic start_cmd, stop_cmd, cfg_wr, conv_end;
  logic scl_rise, scl_fall, start_c, stop_c;

  // Spike filter step: returns next filtered level and run counter
  function automatic logic [4:0] deglitch(input logic s2, input logic f, input logic [3:0] c);
    if (s2 == f)
      deglitch = {f, 4'h0};
    else if (c == 4'(therm_pkg::GLITCH_CYC - 1))
      deglitch = {s2, 4'h0};
    else
      deglitch = {f, c + 4'h1};
  endfunction : deglitch

  function automatic logic [15:0] res_mask(input logic [1:0] r);
    res_mask = 16'(therm_pkg::MASK_12 << (2'h3 - r));
  endfunction : res_mask

  function automatic logic [therm_pkg::CONV_CNT_W-1:0] conv_len(input logic [1:0] r);
    conv_len = therm_pkg::CONV_CNT_W'(conv_cyc_12 >> (2'h3 - r));
  endfunction : conv_len

  nv_store #(.nv_write_cyc(nv_write_cyc)) u_nv (
    .mclk(mclk),
    .resetn(resetn),
    .wr_en(s_r.nv_wr),
    .wr_sel(s_r.nv_sel),
    .wr_data(s_r.nv_dat),
    .th_q(th_q),
    .tl_q(tl_q),
    .cfg_q(nv_cfg),
    .busy(nv_busy)
  );

  assign scl_rise = s_r.scl_f && !s_r.scl_fd;
  assign scl_fall = !s_r.scl_f && s_r.scl_fd;
  assign start_c = s_r.scl_f && s_r.scl_fd && s_r.sda_fd && !s_r.sda_f;
  assign stop_c = s_r.scl_f && s_r.scl_fd && !s_r.sda_fd && s_r.sda_f;
  // Trip points follow the result resolution on compare and on read
  assign thm = th_q & res_mask(s_r.res);
  assign tlm = tl_q & res_mask(s_r.res);
  assign tm = temp_sample & res_mask(s_r.res);
  assign cfg_byte = {s_r.done, s_r.thf, s_r.tlf, nv_busy, s_r.res, nv_cfg};

  always_comb begin
    s_nxt = s_r;
    start_cmd = 1'b0;
    stop_cmd = 1'b0;
    cfg_wr = 1'b0;
    conv_end = 1'b0;
    s_nxt.nv_wr = 1'b0;
    // Synchronisers and spike filters
    s_nxt.scl_s1 = scl_in;
    s_nxt.scl_s2 = s_r.scl_s1;
    {s_nxt.scl_f, s_nxt.scl_cnt} = deglitch(s_r.scl_s2, s_r.scl_f, s_r.scl_cnt);
    s_nxt.scl_fd = s_r.scl_f;
    s_nxt.sda_s1 = sda_in;
    s_nxt.sda_s2 = s_r.sda_s1;
    {s_nxt.sda_f, s_nxt.sda_cnt} = deglitch(s_r.sda_s2, s_r.sda_f, s_r.sda_cnt);
    s_nxt.sda_fd = s_r.sda_f;
    s_nxt.adr_s1 = addr_pins;
    s_nxt.adr_s2 = s_r.adr_s1;
    // Read source selected by the last command
    unique case (s_r.cmd)
      therm_pkg::CMD_READ_TEMP: rword = s_r.temp;
      therm_pkg::CMD_ACCESS_TH: rword = thm;
      therm_pkg::CMD_ACCESS_TL: rword = tlm;
      therm_pkg::CMD_ACCESS_CFG: rword = {cfg_byte, cfg_byte};
      default: rword = 16'hffff;
    endcase
    rbyte = s_r.rd_lo ? rword[7:0] : rword[15:8];
    // Bus slave
    if (start_c) begin
      s_nxt.lst = therm_pkg::L_RX;
      s_nxt.bitcnt = 4'h0;
      s_nxt.byte_idx = 3'h0;
      s_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      s_nxt.lst = therm_pkg::L_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      unique case (s_r.lst)
        therm_pkg::L_IDLE: s_nxt.sda_oe = 1'b0;
        therm_pkg::L_RX: begin
          if (scl_rise) begin
            s_nxt.sh = {s_r.sh[6:0], s_r.sda_f};
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          end else if (scl_fall && s_r.bitcnt == 4'h8) begin
            s_nxt.lst = therm_pkg::L_ACK;
            s_nxt.sda_oe = 1'b1;
            if (s_r.byte_idx != 3'h7)
              s_nxt.byte_idx = s_r.byte_idx + 3'h1;
            if (s_r.byte_idx == 3'h0) begin
              s_nxt.rd = s_r.sh[0];
              s_nxt.rd_lo = 1'b0;
              if (s_r.sh[7:1] != {therm_pkg::DEV_ADDR_HI, s_r.adr_s2}) begin
                s_nxt.lst = therm_pkg::L_IDLE;
                s_nxt.sda_oe = 1'b0;
              end
            end else if (s_r.byte_idx == 3'h1) begin
              s_nxt.cmd = s_r.sh;
              start_cmd = s_r.sh == therm_pkg::CMD_START_CONV;
              stop_cmd = s_r.sh == therm_pkg::CMD_STOP_CONV;
            end else begin
              // Result register has no write path
              s_nxt.wbuf = s_r.sh;
              if (s_r.byte_idx == 3'h3 && (s_r.cmd == therm_pkg::CMD_ACCESS_TH ||
                                           s_r.cmd == therm_pkg::CMD_ACCESS_TL)) begin
                s_nxt.nv_wr = 1'b1;
                s_nxt.nv_sel = (s_r.cmd == therm_pkg::CMD_ACCESS_TH) ?
                               therm_pkg::NV_SEL_TH : therm_pkg::NV_SEL_TL;
                s_nxt.nv_dat = {s_r.wbuf, s_r.sh};
              end
              cfg_wr = s_r.byte_idx == 3'h2 && s_r.cmd == therm_pkg::CMD_ACCESS_CFG;
            end
          end
        end
        therm_pkg::L_ACK: begin
          if (scl_fall) begin
            s_nxt.bitcnt = s_r.rd ? 4'h1 : 4'h0;
            s_nxt.lst = s_r.rd ? therm_pkg::L_TX : therm_pkg::L_RX;
            s_nxt.sh = rbyte;
            s_nxt.sda_oe = s_r.rd && !rbyte[7];
          end
        end
        therm_pkg::L_TX: begin
          if (scl_fall) begin
            if (s_r.bitcnt == 4'h8) begin
              s_nxt.sda_oe = 1'b0;
              s_nxt.lst = therm_pkg::L_TXACK;
              s_nxt.rd_lo = !s_r.rd_lo;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.sda_oe = !s_r.sh[6];
              s_nxt.bitcnt = s_r.bitcnt + 4'h1;
            end
          end
        end
        therm_pkg::L_TXACK: begin
          if (scl_rise && s_r.sda_f) begin
            s_nxt.lst = therm_pkg::L_IDLE;
          end else if (scl_fall) begin
            s_nxt.sh = rbyte;
            s_nxt.sda_oe = !rbyte[7];
            s_nxt.bitcnt = 4'h1;
            s_nxt.lst = therm_pkg::L_TX;
          end
        end
      endcase
    end
    // Configuration write; flags clear on a written zero only
    if (cfg_wr) begin
      s_nxt.res = s_r.sh[therm_pkg::CFG_RES_HI:therm_pkg::CFG_RES_LO];
      s_nxt.thf = s_r.thf & s_r.sh[therm_pkg::CFG_THF];
      s_nxt.tlf = s_r.tlf & s_r.sh[therm_pkg::CFG_TLF];
      s_nxt.nv_wr = 1'b1;
      s_nxt.nv_sel = therm_pkg::NV_SEL_CFG;
      s_nxt.nv_dat = {14'h0000, s_r.sh[therm_pkg::CFG_POL:therm_pkg::CFG_ONESHOT]};
    end
    // Conversion sequencer; the compare uses >= so a resolution change cannot overrun
    unique case (s_r.cst)
      therm_pkg::C_IDLE: begin
        if (start_cmd) begin
          s_nxt.cst = therm_pkg::C_RUN;
          s_nxt.conv_cnt = '0;
          s_nxt.done = 1'b0;
        end
      end
      therm_pkg::C_RUN: begin
        if (stop_cmd) begin
          s_nxt.cst = therm_pkg::C_IDLE;
        end else if (s_r.conv_cnt >= conv_len(s_r.res) - 1'b1) begin
          conv_end = 1'b1;
          s_nxt.conv_cnt = '0;
          if (nv_cfg[therm_pkg::CFG_ONESHOT])
            s_nxt.cst = therm_pkg::C_IDLE;
        end else begin
          s_nxt.conv_cnt = s_r.conv_cnt + 1'b1;
        end
      end
    endcase
    if (conv_end) begin
      s_nxt.temp = tm;
      s_nxt.converted = 1'b1;
      s_nxt.done = 1'b1;
      // Hardware set wins over a clear in the same cycle
      if ($signed(tm) >= $signed(thm)) begin
        s_nxt.act = 1'b1;
        s_nxt.thf = 1'b1;
      end else if ($signed(tm) < $signed(tlm)) begin
        s_nxt.act = 1'b0;
        s_nxt.tlf = 1'b1;
      end
    end
    s_nxt.tout = nv_cfg[therm_pkg::CFG_POL] ? s_nxt.act : !s_nxt.act;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
      {s_r.scl_s1, s_r.scl_s2, s_r.scl_f, s_r.scl_fd} <= 4'hf;
      {s_r.sda_s1, s_r.sda_s2, s_r.sda_f, s_r.sda_fd} <= 4'hf;
      s_r.temp <= therm_pkg::TEMP_POWERUP;
      s_r.done <= therm_pkg::CFG_VOL_RESET[5];
      s_r.thf <= therm_pkg::CFG_VOL_RESET[4];
      s_r.tlf <= therm_pkg::CFG_VOL_RESET[3];
      s_r.res <= therm_pkg::CFG_VOL_RESET[1:0];
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = s_r.sda_oe;
  assign tout = s_r.tout;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_hot;
    conv_end && $signed(tm) >= $signed(thm);
  endsequence
  sequence s_cold;
    conv_end && $signed(tm) < $signed(tlm) && $signed(tm) < $signed(thm);
  endsequence

  property p_conv_bound;
    s_r.cst == therm_pkg::C_RUN |-> s_r.conv_cnt < conv_cyc_12;
  endproperty
  a_conv_bound: assert property (p_conv_bound) else $error("conversion overran");
  property p_glitch;
    $changed(s_r.scl_f) |-> $past(s_r.scl_cnt) == 4'(therm_pkg::GLITCH_CYC - 1);
  endproperty
  a_glitch: assert property (p_glitch) else $error("clock line changed too early");
  property p_temp_src;
    $changed(s_r.temp) |-> $past(conv_end);
  endproperty
  a_temp_src: assert property (p_temp_src) else $error("result changed without conversion");
  property p_powerup;
    !s_r.converted |-> s_r.temp == therm_pkg::TEMP_POWERUP;
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up result lost");
  property p_trip_high;
    s_hot |=> s_r.act && s_r.thf ##0 s_r.tout == $past(nv_cfg[therm_pkg::CFG_POL]);
  endproperty
  a_trip_high: assert property (p_trip_high) else $error("output did not trip");
  property p_trip_low;
    s_cold |=> !s_r.act && s_r.tlf;
  endproperty
  a_trip_low: assert property (p_trip_low) else $error("output did not release");
  property p_res_src;
    $changed(s_r.res) |-> $past(cfg_wr);
  endproperty
  a_res_src: assert property (p_res_src) else $error("resolution changed by itself");
  property p_oneshot;
    conv_end && nv_cfg[therm_pkg::CFG_ONESHOT] |=> s_r.cst == therm_pkg::C_IDLE [*2];
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("single conversion kept running");
  property p_cfg_nv;
    cfg_wr |=> s_r.nv_wr && s_r.nv_sel == therm_pkg::NV_SEL_CFG;
  endproperty
  a_cfg_nv: assert property (p_cfg_nv) else $error("config low bits not sent to nv");
endmodule : therm_core

// ---- design/therm_pkg.sv ----
// Shared constants and state types of the thermometer register set
package therm_pkg;
  // Clock
  localparam int MCLK_MHZ = 250;
  localparam int MCLK_PERIOD_PS = 4000;
  // Spike filter: a change must outlast the widest spike
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS + 1;
  // Conversion time at full resolution, halved for each bit less
  localparam int CONV_US_12 = 750000;
  localparam int CONV_CYC_12 = CONV_US_12 * MCLK_MHZ;
  // Nonvolatile write cycle
  localparam int NV_WRITE_TYP_US = 4000;
  localparam int NV_WRITE_MAX_US = 10000;
  localparam int NV_WRITE_CYC = NV_WRITE_TYP_US * MCLK_MHZ;
  localparam int NV_WRITE_MAX_CYC = NV_WRITE_MAX_US * MCLK_MHZ;
  localparam int NV_CNT_W = 22;
  localparam int CONV_CNT_W = 28;
  // Values after reset, and the 12-bit result mask
  localparam logic [15:0] TEMP_POWERUP = 16'hc400;
  localparam logic [5:0] CFG_VOL_RESET = 6'h23;
  localparam logic [15:0] MASK_12 = 16'hfff0;
  // Factory contents of the nonvolatile cells, arbitrary
  localparam logic [15:0] NV_FACTORY_TH = 16'h0000;
  localparam logic [15:0] NV_FACTORY_TL = 16'h0000;
  localparam logic [1:0] NV_FACTORY_CFG = 2'h0;
  // Configuration byte layout
  localparam int CFG_DONE = 7;
  localparam int CFG_THF = 6;
  localparam int CFG_TLF = 5;
  localparam int CFG_NVB = 4;
  localparam int CFG_RES_HI = 3;
  localparam int CFG_RES_LO = 2;
  localparam int CFG_POL = 1;
  localparam int CFG_ONESHOT = 0;
  // Bus address upper bits, arbitrary
  localparam logic [3:0] DEV_ADDR_HI = 4'h5;
  // Commands
  localparam logic [7:0] CMD_START_CONV = 8'h01;
  localparam logic [7:0] CMD_STOP_CONV = 8'h02;
  localparam logic [7:0] CMD_READ_TEMP = 8'h10;
  localparam logic [7:0] CMD_ACCESS_TH = 8'h11;
  localparam logic [7:0] CMD_ACCESS_TL = 8'h12;
  localparam logic [7:0] CMD_ACCESS_CFG = 8'h13;
  // Nonvolatile cell select
  localparam logic [1:0] NV_SEL_TH = 2'h0;
  localparam logic [1:0] NV_SEL_TL = 2'h1;
  localparam logic [1:0] NV_SEL_CFG = 2'h2;
  // States
  typedef enum logic [2:0] {L_IDLE, L_RX, L_ACK, L_TX, L_TXACK} link_t;
  typedef enum logic {C_IDLE, C_RUN} conv_t;
endpackage : therm_pkg

// ---- design/nv_store.sv ----
// Nonvolatile trip points and low configuration bits with timed write cycle
`timescale 1ns/1ps
module nv_store #(
  parameter int nv_write_cyc = therm_pkg::NV_WRITE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Write request
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [15:0] wr_data,
  // Stored values
  output logic [15:0] th_q,
  output logic [15:0] tl_q,
  output logic [1:0] cfg_q,
  output logic busy
);
  typedef struct packed {
    logic [15:0] th;
    logic [15:0] tl;
    logic [1:0] cfg;
    logic busy;
    logic [therm_pkg::NV_CNT_W-1:0] cnt;
    logic [1:0] sel;
    logic [15:0] data;
  } nv_t;

  // Cells start from factory contents and are never touched by reset
  nv_t s_r = '{th: therm_pkg::NV_FACTORY_TH, tl: therm_pkg::NV_FACTORY_TL,
               cfg: therm_pkg::NV_FACTORY_CFG, busy: 1'b0, cnt: '0, sel: 2'h0,
               data: 16'h0000};
  nv_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (s_r.busy) begin
      if (s_r.cnt == therm_pkg::NV_CNT_W'(nv_write_cyc - 1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.cnt = '0;
        unique case (s_r.sel)
          therm_pkg::NV_SEL_TH: s_nxt.th = s_r.data;
          therm_pkg::NV_SEL_TL: s_nxt.tl = s_r.data;
          therm_pkg::NV_SEL_CFG: s_nxt.cfg = s_r.data[1:0];
          default: s_nxt.busy = 1'b0;
        endcase
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end else if (wr_en) begin
      // A request during a cycle is dropped; the host waits for busy to fall
      s_nxt.busy = 1'b1;
      s_nxt.cnt = '0;
      s_nxt.sel = wr_sel;
      s_nxt.data = wr_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_r.busy <= 1'b0;
      s_r.cnt <= '0;
      s_r.sel <= 2'h0;
      s_r.data <= 16'h0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign th_q = s_r.th;
  assign tl_q = s_r.tl;
  assign cfg_q = s_r.cfg;
  assign busy = s_r.busy;

  property p_nv_bound;
    @(posedge mclk) disable iff (!resetn)
      s_r.busy |-> s_r.cnt < therm_pkg::NV_WRITE_MAX_CYC;
  endproperty
  a_nv_bound: assert property (p_nv_bound) else $error("nv write cycle too long");

  property p_nv_commit;
    @(posedge mclk) disable iff (!resetn)
      $fell(s_r.busy) && $past(s_r.sel) == therm_pkg::NV_SEL_TH |-> s_r.th == $past(s_r.data);
  endproperty
  a_nv_commit: assert property (p_nv_commit) else $error("upper trip not stored");
endmodule : nv_store

// ---- dv/bus_host.sv ----
// Behavioural host controller on the two-wire bus, with optional clock spikes
`timescale 1ns/1ps
module bus_host (
  // Clock used for pacing
  input wire logic mclk,
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda_wire
);
  logic glitch = 1'b0;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : hold

  // Phases far shorter than a real bus needs, each but the optional spike still well past the filter delay
  task automatic bit_io(input logic b, output logic s);
    hold(20);
    if (glitch) begin
      // 40 ns spike, must not count as a clock
      scl = 1'b1;
      hold(10);
      scl = 1'b0;
    end
    hold(20);
    sda_low = !b;
    hold(20);
    scl = 1'b1;
    hold(30);
    s = sda_wire;
    scl = 1'b0;
  endtask : bit_io

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask : get_byte

  // Serves as first and repeated start
  task automatic bus_start();
    hold(20);
    sda_low = 1'b0;
    hold(20);
    scl = 1'b1;
    hold(30);
    sda_low = 1'b1;
    hold(30);
    scl = 1'b0;
  endtask : bus_start

  task automatic bus_stop();
    hold(20);
    sda_low = 1'b1;
    hold(20);
    scl = 1'b1;
    hold(30);
    sda_low = 1'b0;
    // Bus free time, longer than the shortened nonvolatile write cycle
    hold(60);
  endtask : bus_stop
endmodule : bus_host

// ---- dv/tb_thermometer_register_set.sv ----
// Self-checking bench of the thermometer register set
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module tb_thermometer_register_set;
  logic mclk = 1'b0;
  logic resetn;
  logic [2:0] addr_pins;
  logic [15:0] temp_sample;
  logic scl_in;
  logic sda_out;
  logic sda_oe;
  logic tout;
  logic host_low;
  logic sda_wire;
  int seed = 18382;
  int n_mismatch = 0;
  int checks = 0;
  logic [15:0] th;
  logic [15:0] tl;
  logic [15:0] hi;
  logic [15:0] lo;
  logic [15:0] v;
  logic [31:0] r;

  always #2 mclk = ~mclk;

  // Open drain with pull-up
  assign sda_wire = !(host_low || (sda_oe && !sda_out));

  bus_host host (
    .mclk(mclk),
    .scl(scl_in),
    .sda_low(host_low),
    .sda_wire(sda_wire)
  );

  therm_core #(.conv_cyc_12(64), .nv_write_cyc(20)) DUT (
    .mclk(mclk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_wire),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .addr_pins(addr_pins),
    .temp_sample(temp_sample),
    .tout(tout)
  );

  function automatic logic [15:0] masked(input logic [15:0] d, input logic [1:0] res);
    return d & (16'hffff << (7 - res));
  endfunction : masked

  function automatic logic [7:0] cfg_exp(input logic done, input logic thf, input logic tlf,
                                         input logic [1:0] res, input logic output_polarity_bit, input logic one);
    return {done, thf, tlf, 1'b0, res, output_polarity_bit, one};
  endfunction : cfg_exp

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  // Command write, nw data bytes high first, then nr bytes read after a repeated start
  task automatic xfer(input logic [7:0] cmd, input int nw, input logic [15:0] wd, input int nr,
                      output logic [15:0] rd);
    logic ok;
    logic a;
    logic [7:0] b;
    ok = 1'b1;
    rd = 16'h0000;
    host.bus_start();
    host.put_byte({therm_pkg::DEV_ADDR_HI, addr_pins, 1'b0}, a);
    ok &= a;
    host.put_byte(cmd, a);
    ok &= a;
    for (int i = nw; i > 0; i--) begin
      host.put_byte(wd[8*i-1 -: 8], a);
      ok &= a;
    end
    if (nr > 0) begin
      host.bus_start();
      host.put_byte({therm_pkg::DEV_ADDR_HI, addr_pins, 1'b1}, a);
      ok &= a;
      for (int i = nr; i > 0; i--) begin
        host.get_byte(i == 1, b);
        rd = {rd[7:0], b};
      end
    end
    host.bus_stop();
    `CHK("ack", 1'b1, ok)
  endtask : xfer

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    // About twice a clean run
    #400_000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    resetn = 1'b0;
    temp_sample = 16'h0000;
    r = $random(seed);
    addr_pins = r[2:0];
    repeat (16) @(posedge mclk);
    #1;
    resetn = 1'b1;
    step(2);
    // Power-up state; the data byte aimed at the result must be ignored
    `CHK("tout idle", 1'b1, tout)
    xfer(therm_pkg::CMD_READ_TEMP, 1, 16'h00a5, 2, v);
    `CHK("result", 16'hc400, v)
    xfer(therm_pkg::CMD_ACCESS_CFG, 0, 16'h0000, 1, v);
    `CHK("config", cfg_exp(1'b1, 1'b0, 1'b0, 2'b11, 1'b0, 1'b0), v[7:0])
    $display("test reset done");
    // Trip points; the upper one crosses the bus with clock spikes
    r = $random(seed);
    th = {2'b00, r[5:0], r[15:8]} + 16'h0800;
    tl = {2'b11, r[29:16]};
    host.glitch = 1'b1;
    xfer(therm_pkg::CMD_ACCESS_TH, 2, th, 0, v);
    host.glitch = 1'b0;
    xfer(therm_pkg::CMD_ACCESS_TL, 2, tl, 0, v);
    xfer(therm_pkg::CMD_ACCESS_TH, 0, 16'h0000, 2, v);
    `CHK("upper trip", masked(th, 2'b11), v)
    xfer(therm_pkg::CMD_ACCESS_TL, 0, 16'h0000, 2, v);
    `CHK("lower trip", masked(tl, 2'b11), v)
    $display("test trip points done");
    // 9-bit resolution, active-high output, one conversion per start
    xfer(therm_pkg::CMD_ACCESS_CFG, 1, 16'h0003, 0, v);
    `CHK("tout polarity", 1'b0, tout)
    $display("test config done");
    r = $random(seed);
    hi = masked(th, 2'b00) + 16'h0100 + {8'h00, r[7:0]};
    lo = masked(tl, 2'b00) - 16'h0080 + {9'h000, r[14:8]};
    temp_sample = hi;
    xfer(therm_pkg::CMD_START_CONV, 0, 16'h0000, 0, v);
    step(20);
    `CHK("tout high", 1'b1, tout)
    // Idle after the single conversion: a new sample must not move the output
    temp_sample = lo;
    step(40);
    `CHK("tout held", 1'b1, tout)
    xfer(therm_pkg::CMD_START_CONV, 0, 16'h0000, 0, v);
    step(20);
    `CHK("tout low", 1'b0, tout)
    xfer(therm_pkg::CMD_ACCESS_CFG, 0, 16'h0000, 1, v);
    `CHK("flags", cfg_exp(1'b1, 1'b1, 1'b1, 2'b00, 1'b1, 1'b1), v[7:0])
    xfer(therm_pkg::CMD_READ_TEMP, 0, 16'h0000, 2, v);
    `CHK("result 9b", masked(lo, 2'b00), v)
    $display("test conversion done");
    // Second power-up: volatile state restarts, nonvolatile cells keep their values
    resetn = 1'b0;
    step(4);
    resetn = 1'b1;
    step(2);
    `CHK("tout after reset", 1'b0, tout)
    xfer(therm_pkg::CMD_ACCESS_CFG, 0, 16'h0000, 1, v);
    `CHK("config kept", cfg_exp(1'b1, 1'b0, 1'b0, 2'b11, 1'b1, 1'b1), v[7:0])
    xfer(therm_pkg::CMD_READ_TEMP, 0, 16'h0000, 2, v);
    `CHK("result reset", 16'hc400, v)
    xfer(therm_pkg::CMD_ACCESS_TH, 0, 16'h0000, 2, v);
    `CHK("upper kept", masked(th, 2'b11), v)
    $display("test retention done");
    // Continuous conversions at 12 bits, active-low output, then a stop
    xfer(therm_pkg::CMD_ACCESS_CFG, 1, 16'h000c, 0, v);
    temp_sample = hi;
    xfer(therm_pkg::CMD_START_CONV, 0, 16'h0000, 0, v);
    `CHK("tout active low", 1'b0, tout)
    temp_sample = lo;
    step(150);
    `CHK("tout follows", 1'b1, tout)
    xfer(therm_pkg::CMD_STOP_CONV, 0, 16'h0000, 0, v);
    temp_sample = hi;
    step(150);
    `CHK("tout after stop", 1'b1, tout)
    $display("test continuous done");
    finish_test();
  end
endmodule : tb_thermometer_register_set
